//--- verilog/rtcsb_params.svh
// Constants for the clocked memory with calendar bytes.
// Assumes a 200 MHz reference clock; included by the package users.
`ifndef RTCSB_PARAMS_SVH
`define RTCSB_PARAMS_SVH

// Clock and access times, in ns
`define RTCSB_CLK_PERIOD_NS     5
`define RTCSB_ADDR_ACCESS_NS    100
`define RTCSB_SEL_ACCESS_NS     100
`define RTCSB_DRV_ACCESS_NS     50
`define RTCSB_OUT_HOLD_NS       5
// Longest times round down, least times round up
`define RTCSB_ADDR_ACCESS_CYC   (`RTCSB_ADDR_ACCESS_NS / `RTCSB_CLK_PERIOD_NS)
`define RTCSB_SEL_ACCESS_CYC    (`RTCSB_SEL_ACCESS_NS / `RTCSB_CLK_PERIOD_NS)
`define RTCSB_DRV_ACCESS_CYC    (`RTCSB_DRV_ACCESS_NS / `RTCSB_CLK_PERIOD_NS)
`define RTCSB_OUT_HOLD_CYC \
  ((`RTCSB_OUT_HOLD_NS + `RTCSB_CLK_PERIOD_NS - 1) / `RTCSB_CLK_PERIOD_NS)
// One second of reference clock
`define RTCSB_SEC_CYCLES        200000000

// Memory map
`define RTCSB_MEM_WORDS         8192
`define RTCSB_CTRL_ADDR         13'h1ff8
`define RTCSB_CLK_BYTES         3'h7
`define RTCSB_HALT_BIT          6

// Data shown while the access is not complete
`define RTCSB_DATA_UNDEF        8'h00

// Calendar reset values and limits (BCD)
`define RTCSB_RST_ONE           8'h01
`define RTCSB_RST_ZERO          8'h00
`define RTCSB_MAX_SEC           8'h59
`define RTCSB_MAX_HOUR          8'h23
`define RTCSB_MAX_DAY           8'h07
`define RTCSB_MAX_MONTH         8'h12
`define RTCSB_MAX_YEAR          8'h99
`endif

//--- verilog/rtcsb_pkg.sv
// Types for the clocked memory with calendar bytes.
// Assumes rtcsb_params.svh supplies all numeric constants.
package rtcsb_pkg;
  typedef logic [7:0]  rtcsb_byte_t;
  typedef logic [12:0] rtcsb_addr_t;

  // Bus mode, Gray coded along standby-read-write
  typedef enum logic [1:0] {
    RTCSB_STANDBY = 2'b00,
    RTCSB_READ    = 2'b01,
    RTCSB_WRITE   = 2'b11
  } rtcsb_mode_e;

  // Synchronised bus and supply monitor pins
  typedef struct packed {
    rtcsb_addr_t addr;
    logic        sel_n;
    logic        sel;
    logic        drv_n;
    logic        wr_n;
    rtcsb_byte_t din;
    logic        supply_ok;
    logic        below_so;
  } rtcsb_pins_s;

  // Live calendar counters, all BCD
  typedef struct packed {
    rtcsb_byte_t year;
    rtcsb_byte_t month;
    rtcsb_byte_t date;
    rtcsb_byte_t day;
    rtcsb_byte_t hour;
    rtcsb_byte_t min;
    rtcsb_byte_t sec;
  } rtcsb_time_s;
endpackage

//--- verilog/rtcsb_top.sv
// Byte-wide static memory whose top eight bytes carry a calendar clock.
// Assumes an unclocked host on the pins; every pin is synchronised here.
// What this block does
// R1: Clock bytes sit at top eight addresses
// R2: Calendar kept in BCD, 24-hour hours
// R3: Month lengths and leap years handled
// R4: Lowest clock byte is control register
// R5: Counters copied into clock bytes each second
// R6: Clock bytes use ordinary memory timing
// R7: Writes blocked while supply out of tolerance
// R8: Battery powers memory below switchover
// R9: Read needs write high, both selects active
// R10: Thirteen address lines select one of 8192
// R11: Data valid after latest access interval
// R12: Drive data only when selected and enabled
// R13: Early enable drives undefined data
// R14: Address change keeps old data briefly
// R15: Write spans overlap of strobe and selects
// R16: Falling write strobe releases data lines
// R17: Either select inactive means standby
// R18: Host spaces accesses, samples after intervals
`timescale 1ns/100ps
`include "rtcsb_params.svh"

module rtcsb_top #(
  parameter int unsigned SEC_CYCLES = `RTCSB_SEC_CYCLES
) (
  // Clock and reset
  input  wire logic           REF_CLK,
  input  wire logic           RESETN,
  // Memory bus controls
  input  wire logic [12:0]    BYTE_SELECT_LINES,
  input  wire logic           SELECT_LOW_ACTIVE_N,
  input  wire logic           SELECT_HIGH_ACTIVE,
  input  wire logic           DRIVE_ENABLE_N,
  input  wire logic           WRITE_STROBE_N,
  // Three-state data lines
  input  rtcsb_pkg::rtcsb_byte_t DATA_LINES_I,
  output rtcsb_pkg::rtcsb_byte_t DATA_LINES_O,
  output logic                DATA_LINES_OE,
  // Supply monitor
  input  wire logic           SUPPLY_IN_TOLERANCE,
  input  wire logic           SUPPLY_BELOW_SWITCHOVER,
  output logic                POWER_FROM_BATTERY,
  output logic                STANDBY
);
  import rtcsb_pkg::*;

  localparam int unsigned ADDR_CYC = `RTCSB_ADDR_ACCESS_CYC;
  localparam int unsigned SEL_CYC  = `RTCSB_SEL_ACCESS_CYC;
  localparam int unsigned DRV_CYC  = `RTCSB_DRV_ACCESS_CYC;
  localparam logic [1:0]  HOLD_CYC = 2'(`RTCSB_OUT_HOLD_CYC);

  // Saturating access timer step
  function automatic logic [4:0] sat_inc(input logic [4:0] c);
    sat_inc = (c == 5'h1f) ? c : c + 5'h01;
  endfunction

  // BCD step with wrap from hi back to lo
  function automatic rtcsb_byte_t bcd_inc(input rtcsb_byte_t v, input rtcsb_byte_t lo,
                                          input rtcsb_byte_t hi);
    if (v == hi) begin
      bcd_inc = lo;
    end else if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = v + 8'h01;
    end
  endfunction

  // Year 00 counts as leap, right through 2100
  function automatic logic is_leap(input rtcsb_byte_t y);
    is_leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                   : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
  endfunction

  function automatic rtcsb_byte_t last_date(input rtcsb_byte_t m, input rtcsb_byte_t y);
    if (m == 8'h02) begin
      last_date = is_leap(y) ? 8'h29 : 8'h28;
    end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
      last_date = 8'h30;
    end else begin
      last_date = 8'h31;
    end
  endfunction

  // Two-flop synchroniser on every pin
  rtcsb_pins_s pin_raw;
  rtcsb_pins_s pin1_q;
  rtcsb_pins_s pin2_q;
  assign pin_raw = '{addr: BYTE_SELECT_LINES, sel_n: SELECT_LOW_ACTIVE_N,
                     sel: SELECT_HIGH_ACTIVE, drv_n: DRIVE_ENABLE_N, wr_n: WRITE_STROBE_N,
                     din: DATA_LINES_I, supply_ok: SUPPLY_IN_TOLERANCE,
                     below_so: SUPPLY_BELOW_SWITCHOVER};

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pin1_q <= '{sel_n: 1'b1, drv_n: 1'b1, wr_n: 1'b1, default: '0};
      pin2_q <= '{sel_n: 1'b1, drv_n: 1'b1, wr_n: 1'b1, default: '0};
    end else begin
      pin1_q <= pin_raw;
      pin2_q <= pin1_q;
    end
  end

  logic sel_act;
  logic drv_act;
  logic wr_act;
  logic pwr_ok;
  assign sel_act = pin2_q.sel && !pin2_q.sel_n;  // R17
  assign drv_act = !pin2_q.drv_n;
  assign wr_act  = !pin2_q.wr_n;
  assign pwr_ok  = pin2_q.supply_ok;

  // Bus state, access timers and output drivers
  rtcsb_mode_e mode_q, mode_d;
  rtcsb_addr_t addr_q, addr_d, wr_addr_q, wr_addr_d;
  rtcsb_byte_t wr_data_q, wr_data_d, dout_d;
  logic [4:0]  acc_a_q, acc_a_d, acc_s_q, acc_s_d, acc_g_q, acc_g_d;
  logic [1:0]  hold_q, hold_d;
  logic        data_ok_q, data_ok_d, drive_d, commit;
  logic        batt_d, stby_d;
  logic        addr_chg;
  rtcsb_byte_t rd_q;

  always_comb begin
    mode_d = RTCSB_STANDBY;
    if (pwr_ok && sel_act) begin  // R7
      mode_d = wr_act ? RTCSB_WRITE : RTCSB_READ;  // R9 R15
    end
    addr_chg  = pin2_q.addr != addr_q;
    addr_d    = pin2_q.addr;
    // Write data and address taken at the last cycle of the overlap
    wr_addr_d = (mode_d == RTCSB_WRITE) ? pin2_q.addr : wr_addr_q;  // R15
    wr_data_d = (mode_d == RTCSB_WRITE) ? pin2_q.din : wr_data_q;
    commit    = (mode_q == RTCSB_WRITE) && (mode_d != RTCSB_WRITE) && pwr_ok;  // R7 R15
    acc_a_d   = addr_chg ? 5'h00 : sat_inc(acc_a_q);  // R11
    acc_s_d   = sel_act ? sat_inc(acc_s_q) : 5'h00;
    acc_g_d   = drv_act ? sat_inc(acc_g_q) : 5'h00;
    hold_d    = addr_chg ? HOLD_CYC : ((hold_q != 2'h0) ? hold_q - 2'h1 : 2'h0);
    data_ok_d = (acc_a_d >= 5'(ADDR_CYC)) && (acc_s_d >= 5'(SEL_CYC))
                && (acc_g_d >= 5'(DRV_CYC));  // R11 R6
    drive_d   = (mode_d == RTCSB_READ) && drv_act;  // R12 R16
    // Old data during hold, then undefined until the access completes
    if (!drive_d) begin
      dout_d = `RTCSB_DATA_UNDEF;  // R12
    end else if (data_ok_d) begin
      dout_d = rd_q;
    end else if (hold_d != 2'h0 && DATA_LINES_OE) begin
      dout_d = DATA_LINES_O;  // R14
    end else begin
      dout_d = `RTCSB_DATA_UNDEF;  // R13
    end
    batt_d = pin2_q.below_so;  // R8
    stby_d = mode_d == RTCSB_STANDBY;  // R17
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      mode_q             <= RTCSB_STANDBY;
      addr_q             <= '0;
      wr_addr_q          <= '0;
      wr_data_q          <= '0;
      acc_a_q            <= '0;
      acc_s_q            <= '0;
      acc_g_q            <= '0;
      hold_q             <= '0;
      data_ok_q          <= 1'b0;
      DATA_LINES_O       <= `RTCSB_DATA_UNDEF;
      DATA_LINES_OE      <= 1'b0;
      POWER_FROM_BATTERY <= 1'b0;
      STANDBY            <= 1'b1;
    end else begin
      mode_q             <= mode_d;
      addr_q             <= addr_d;
      wr_addr_q          <= wr_addr_d;
      wr_data_q          <= wr_data_d;
      acc_a_q            <= acc_a_d;
      acc_s_q            <= acc_s_d;
      acc_g_q            <= acc_g_d;
      hold_q             <= hold_d;
      data_ok_q          <= data_ok_d;
      DATA_LINES_O       <= dout_d;
      DATA_LINES_OE      <= drive_d;
      POWER_FROM_BATTERY <= batt_d;
      STANDBY            <= stby_d;
    end
  end

  // Calendar counters and the once-a-second copy into the clock bytes
  rtcsb_time_s time_q, time_d;
  logic [27:0] div_q, div_d;
  logic        tick_q, tick_d;
  logic [2:0]  copy_q, copy_d;
  rtcsb_byte_t ctrl_q, ctrl_d;
  logic        mem_we;
  rtcsb_addr_t mem_wa;
  rtcsb_byte_t mem_wd, copy_byte;

  always_comb begin
    div_d  = (div_q == 28'(SEC_CYCLES - 1)) ? 28'h0 : div_q + 28'h1;
    tick_d = div_q == 28'(SEC_CYCLES - 1);
    time_d = time_q;
    // Counters keep running on battery too
    if (tick_q) begin
      time_d.sec = bcd_inc(time_q.sec, 8'h00, `RTCSB_MAX_SEC);  // R2
      if (time_q.sec == `RTCSB_MAX_SEC) begin
        time_d.min = bcd_inc(time_q.min, 8'h00, `RTCSB_MAX_SEC);
        if (time_q.min == `RTCSB_MAX_SEC) begin
          time_d.hour = bcd_inc(time_q.hour, 8'h00, `RTCSB_MAX_HOUR);  // R2
          if (time_q.hour == `RTCSB_MAX_HOUR) begin
            time_d.day  = bcd_inc(time_q.day, 8'h01, `RTCSB_MAX_DAY);
            time_d.date = bcd_inc(time_q.date, 8'h01,
                                  last_date(time_q.month, time_q.year));  // R3
            if (time_q.date == last_date(time_q.month, time_q.year)) begin
              time_d.month = bcd_inc(time_q.month, 8'h01, `RTCSB_MAX_MONTH);
              if (time_q.month == `RTCSB_MAX_MONTH) begin
                time_d.year = bcd_inc(time_q.year, 8'h00, `RTCSB_MAX_YEAR);
              end
            end
          end
        end
      end
    end
    // Host writes to the control byte steer the copy
    ctrl_d = (commit && wr_addr_q == `RTCSB_CTRL_ADDR) ? wr_data_q : ctrl_q;  // R4
    copy_d = copy_q;
    if (tick_q && !ctrl_q[`RTCSB_HALT_BIT] && copy_q == 3'h0) begin
      copy_d = `RTCSB_CLK_BYTES;  // R5
    end else if (copy_q != 3'h0 && !commit) begin
      copy_d = copy_q - 3'h1;
    end
    case (copy_q)
      3'h1:    copy_byte = time_q.sec;
      3'h2:    copy_byte = time_q.min;
      3'h3:    copy_byte = time_q.hour;
      3'h4:    copy_byte = time_q.day;
      3'h5:    copy_byte = time_q.date;
      3'h6:    copy_byte = time_q.month;
      default: copy_byte = time_q.year;
    endcase
    // Host write wins; the copy waits one cycle
    mem_we = commit || (copy_q != 3'h0);
    mem_wa = commit ? wr_addr_q : `RTCSB_CTRL_ADDR + {10'h0, copy_q};  // R1
    mem_wd = commit ? wr_data_q : copy_byte;
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      time_q <= '{month: `RTCSB_RST_ONE, date: `RTCSB_RST_ONE, day: `RTCSB_RST_ONE,
                  default: `RTCSB_RST_ZERO};
      div_q  <= '0;
      tick_q <= 1'b0;
      copy_q <= '0;
      ctrl_q <= '0;
    end else begin
      time_q <= time_d;
      div_q  <= div_d;
      tick_q <= tick_d;
      copy_q <= copy_d;
      ctrl_q <= ctrl_d;
    end
  end

  // Byte array, no reset: contents survive on battery
  rtcsb_byte_t mem [`RTCSB_MEM_WORDS];
  always_ff @(posedge REF_CLK) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;  // R10
    end
    rd_q <= mem[pin2_q.addr];  // R10 R6
  end

  // Checks on the pin behaviour, the clock byte copy and the calendar ranges
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);

  property p_drive_only_read;
    DATA_LINES_OE |-> $past(sel_act && drv_act && !wr_act && pwr_ok);
  endproperty
  a_drive_only_read: assert property (p_drive_only_read) else $error("drive outside read"); // R12

  property p_wr_release;
    (DATA_LINES_OE && wr_act) |=> !DATA_LINES_OE;
  endproperty
  a_wr_release: assert property (p_wr_release) else $error("write strobe kept drive"); // R16

  property p_no_write_low_supply;
    !pwr_ok |-> !commit;
  endproperty
  a_no_write_low_supply: assert property (p_no_write_low_supply) else $error("write unsafe"); // R7

  property p_deselect;
    !sel_act |=> (!DATA_LINES_OE && STANDBY);
  endproperty
  a_deselect: assert property (p_deselect) else $error("not in standby"); // R17

  property p_drv_access;
    $rose(drv_act) |=> !data_ok_q [*8];
  endproperty
  a_drv_access: assert property (p_drv_access) else $error("data valid too early"); // R11

  property p_undef_early;
    (DATA_LINES_OE && !data_ok_q && hold_q == 2'h0) |-> DATA_LINES_O == `RTCSB_DATA_UNDEF;
  endproperty
  a_undef_early: assert property (p_undef_early) else $error("early data not undefined"); // R13

  property p_hold;
    (addr_chg && drive_d && DATA_LINES_OE && data_ok_q) |=> $stable(DATA_LINES_O);
  endproperty
  a_hold: assert property (p_hold) else $error("old data not held"); // R14

  property p_copy_len;
    $rose(copy_q != 3'h0) |-> ##[7:30] (copy_q == 3'h0);
  endproperty
  a_copy_len: assert property (p_copy_len) else $error("copy did not finish"); // R5

  property p_bcd_range;
    (time_q.sec <= `RTCSB_MAX_SEC) && (time_q.hour <= `RTCSB_MAX_HOUR)
      && (time_q.date <= 8'h31) && (time_q.sec[3:0] <= 4'h9);
  endproperty
  a_bcd_range: assert property (p_bcd_range) else $error("calendar out of range"); // R2

  c_read_valid: cover property (DATA_LINES_OE && data_ok_q);
  c_write_commit: cover property (commit);
  c_clock_copy: cover property ($rose(copy_q != 3'h0));
  c_hold_seen: cover property (DATA_LINES_OE && !data_ok_q && hold_q != 2'h0);
endmodule

//--- bench/rtcsb_host.sv
// Host model for the byte-wide bus: drives the pins and samples reads.
// Assumes the bench resolves the shared data wire from the device enable.
`timescale 1ns/100ps
module rtcsb_host (
  // Clock and shared wire
  input  wire logic              clk,
  input  rtcsb_pkg::rtcsb_byte_t bus,
  // Bus pins
  output logic [12:0]            addr,
  output logic [3:0]             ctl,
  output rtcsb_pkg::rtcsb_byte_t dout,
  output logic                   den,
  // Read result
  output logic                   rd_stb,
  output rtcsb_pkg::rtcsb_byte_t rd_val
);
  import rtcsb_pkg::*;
  // ctl = {low-active select, high-active select, enable_n, strobe_n}
  localparam logic [3:0] IDLE = 4'hb;
  localparam logic [3:0] RD   = 4'h5;
  localparam logic [3:0] WR   = 4'h6;

  // Quiet bus at time zero
  initial begin
    {addr, ctl, dout, den, rd_stb, rd_val} = {13'h0000, IDLE, 8'h00, 1'b0, 1'b0, 8'h00};
  end

  // Pins move just after an edge; a released wire shows the inverse
  task automatic pins(input logic [12:0] a, input logic [3:0] c, input logic e,
                      input rtcsb_byte_t d);
    @(posedge clk);
    #1;
    rd_stb = 1'b0;
    addr = a;
    ctl = c;
    if (e)
      dout = d;
    else if (den)
      dout = ~dout;
    den = e;
  endtask

  // Sample only once every access interval has run out
  task automatic read(input logic [12:0] a, input bit emit, output rtcsb_byte_t v);
    pins(a, RD, 1'b0, 8'h00);
    repeat (30) @(posedge clk);
    v = bus;
    #1;
    rd_val = v;
    rd_stb = emit;
    pins(a, IDLE, 1'b0, 8'h00);
    repeat (22) @(posedge clk);
  endtask

  // Strobe rises first, selects and data held one more cycle
  task automatic write(input logic [12:0] a, input rtcsb_byte_t d);
    pins(a, WR, 1'b1, d);
    repeat (5) @(posedge clk);
    pins(a, 4'h7, 1'b1, d);
    pins(a, IDLE, 1'b0, d);
    repeat (20) @(posedge clk);
  endtask
endmodule

//--- bench/rtcsb_top_bench.sv
// Self-checking bench for the clocked memory with calendar bytes.
// Assumes the host model in rtcsb_host.sv; seconds shortened to 50 cycles.
`timescale 1ns/100ps
module rtcsb_top_bench;
  import rtcsb_pkg::*;
  localparam int SEC = 50;
  logic        REF_CLK, RESETN, SUPPLY_IN_TOLERANCE, SUPPLY_BELOW_SWITCHOVER;
  logic [12:0] addr;
  logic [3:0]  ctl;
  logic        den, rd_stb, oe, batt, stby;
  rtcsb_byte_t dout, rd_val, dq_o, bus, v, s1;
  rtcsb_byte_t exp_q[$];
  rtcsb_byte_t dl[18];
  logic [12:0] al[18];
  rtcsb_byte_t cal[5] = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
  logic [3:0]  dc[3] = '{4'hd, 4'h1, 4'h7};
  int          n_errors = 0;
  int          n_checks = 0;
  int          seed = 52;

  // Device output wins the wire; else the host drive or its inverse
  assign bus = oe ? dq_o : dout;

  rtcsb_top #(.SEC_CYCLES(SEC)) dut (
    .REF_CLK(REF_CLK), .RESETN(RESETN), .BYTE_SELECT_LINES(addr),
    .SELECT_LOW_ACTIVE_N(ctl[3]), .SELECT_HIGH_ACTIVE(ctl[2]),
    .DRIVE_ENABLE_N(ctl[1]), .WRITE_STROBE_N(ctl[0]),
    .DATA_LINES_I(bus), .DATA_LINES_O(dq_o), .DATA_LINES_OE(oe),
    .SUPPLY_IN_TOLERANCE(SUPPLY_IN_TOLERANCE),
    .SUPPLY_BELOW_SWITCHOVER(SUPPLY_BELOW_SWITCHOVER),
    .POWER_FROM_BATTERY(batt), .STANDBY(stby));

  rtcsb_host host (.clk(REF_CLK), .bus(bus), .addr(addr), .ctl(ctl), .dout(dout),
                   .den(den), .rd_stb(rd_stb), .rd_val(rd_val));

  // Comparisons
  task automatic chk_byte(input rtcsb_byte_t got, input rtcsb_byte_t exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // Helpers; cyc leaves us just past the edge so outputs are settled
  task automatic cyc(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask
  task automatic rd_exp(input logic [12:0] a, input rtcsb_byte_t e);
    exp_q.push_back(e);
    host.read(a, 1'b1, v);
  endtask
  task automatic supply(input logic ok, input logic lo);
    @(posedge REF_CLK);
    #1;
    SUPPLY_IN_TOLERANCE = ok;
    SUPPLY_BELOW_SWITCHOVER = lo;
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Read results are matched against the oldest note
  always @(posedge REF_CLK) begin
    if (rd_stb === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("[FAIL] %0t read with no expectation", $time);
      end else
        chk_byte(rd_val, exp_q.pop_front());
    end
  end

  // Clock
  initial begin
    REF_CLK = 1'b0;
    forever #2.5 REF_CLK = ~REF_CLK;
  end

  // Watchdog, well past the expected few thousand cycles
  initial begin
    #200000;
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end

  initial begin
    RESETN = 1'b0;
    SUPPLY_IN_TOLERANCE = 1'b1;
    SUPPLY_BELOW_SWITCHOVER = 1'b0;
    cyc(3);
    chk_bit(oe, 1'b0);
    chk_bit(stby, 1'b1);
    chk_bit(batt, 1'b0);
    RESETN = 1'b1;
    // First copy lands one second after reset; before it the clock bytes are empty
    cyc(SEC + 12);
    // Calendar: halt copies, seconds must freeze and hour to year read as reset values
    host.write(13'h1ff8, 8'h40);
    host.read(13'h1ff9, 1'b0, s1);
    chk_byte(s1, 8'h01);
    cyc(4 * SEC);
    host.read(13'h1ff9, 1'b0, v);
    chk_byte(v, s1);
    for (int i = 0; i < 5; i++)
      rd_exp(13'h1ffb + 13'(i), cal[i]);
    rd_exp(13'h1ff8, 8'h40);
    host.write(13'h1ff8, 8'h00);
    cyc(4 * SEC);
    host.read(13'h1ff9, 1'b0, v);
    chk_bit(v > s1, 1'b1);
    chk_bit(v[3:0] <= 4'h9 && v[7:4] <= 4'h5, 1'b1);
    $display("test calendar done");
    // Walking-one, boundary and random addresses, distinct data
    for (int i = 0; i < 18; i++) begin
      al[i] = (i < 13) ? 13'(1) << i : (i == 13) ? 13'h0000 : (i == 14) ? 13'h1ff7 :
              {4'he, 2'(i - 15), 7'($random(seed))};
      dl[i] = {5'(i), 3'($random(seed))};
      host.write(al[i], dl[i]);
    end
    for (int i = 0; i < 18; i++)
      rd_exp(al[i], dl[i]);
    $display("test decode done");
    // Early enable, then address change mid-read
    host.pins(al[1], 4'h5, 1'b0, 8'h00);
    cyc(6);
    chk_bit(oe, 1'b1);
    chk_byte(dq_o, 8'h00);
    cyc(30);
    chk_byte(dq_o, dl[1]);
    host.pins(al[2], 4'h5, 1'b0, 8'h00);
    cyc(8);
    chk_byte(dq_o, 8'h00);
    cyc(30);
    chk_byte(dq_o, dl[2]);
    // Strobe falls while driving: outputs must let go
    host.pins(al[2], 4'h4, 1'b1, 8'h3c);
    cyc(5);
    chk_bit(oe, 1'b0);
    host.pins(al[2], 4'h7, 1'b1, 8'h3c);
    host.pins(al[2], 4'hb, 1'b0, 8'h3c);
    cyc(20);
    rd_exp(al[2], 8'h3c);
    $display("test timing done");
    // Deselect codes and read with enable high
    for (int i = 0; i < 3; i++) begin
      host.pins(al[3], dc[i], 1'b0, 8'h00);
      cyc(8);
      chk_bit(oe, 1'b0);
      chk_bit(stby, i < 2);
    end
    host.pins(al[3], 4'hb, 1'b0, 8'h00);
    cyc(20);
    $display("test deselect done");
    // Supply out of tolerance: no write, no drive; then battery switch
    supply(1'b0, 1'b0);
    host.write(al[3], ~dl[3]);
    host.pins(al[3], 4'h5, 1'b0, 8'h00);
    cyc(8);
    chk_bit(oe, 1'b0);
    chk_bit(stby, 1'b1);
    host.pins(al[3], 4'hb, 1'b0, 8'h00);
    supply(1'b0, 1'b1);
    cyc(5);
    chk_bit(batt, 1'b1);
    supply(1'b1, 1'b0);
    cyc(5);
    chk_bit(batt, 1'b0);
    rd_exp(al[3], dl[3]);
    chk_bit(exp_q.size() == 0, 1'b1);
    $display("test supply done");
    print_verdict();
  end
endmodule
